// >>> common/bpio_pkg.sv
// package for the board pulse-width i/o block: widths, reset values, timing counts
// assumes a single 25 MHz fabric clock and synchronous active-high reset
package bpio_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned AUDIO_BW_HZ = 5_000;
  localparam int unsigned PWM_OVERSAMPLE = 10;
  localparam int unsigned AUDIO_PWM_MIN_HZ = AUDIO_BW_HZ * PWM_OVERSAMPLE;
  localparam int unsigned PERIOD_BITS = 8;
  localparam int unsigned PWM_PERIOD = 256;
  localparam int unsigned PWM_HZ = CLK_HZ / PWM_PERIOD;
  localparam int unsigned RGB_DUTY_MAX = PWM_PERIOD / 2;
  localparam int unsigned NUM_BTN = 4;
  localparam int unsigned NUM_SW = 2;
  localparam int unsigned NUM_LED = 4;
  localparam int unsigned NUM_RGB = 2;
  localparam int unsigned NUM_COLOR = 3;
  localparam int unsigned NUM_CHAN = NUM_RGB * NUM_COLOR;
  localparam logic [PERIOD_BITS-1:0] CNT_RESET = 8'h00;
  localparam logic [PERIOD_BITS-1:0] DUTY_RESET = 8'h00;
  localparam logic [PERIOD_BITS:0] RGB_LIMIT = 9'h080;
  localparam int unsigned SHIELD_PULSE_US = 10;
  localparam int unsigned SHIELD_PULSE_CYC = (SHIELD_PULSE_US * (CLK_HZ / 1_000_000));

  typedef struct packed {
    logic [NUM_BTN-1:0] btn;
    logic [NUM_SW-1:0] sw;
    logic phy_clk_ok;
    logic sys_rst_btn;
    logic power_good;
  } bpio_pins_t;
endpackage

// >>> rtl/bpio_top.sv
// board pulse-width i/o: rgb led and audio pwm, single leds, buttons, switches, resets
// assumes pin inputs asynchronous to mclk_i; board pull-up on the audio line
// How it works
// - buttons read high only while pressed
// - switch level follows only its position
// - single led lit when pin high
// - each colour lit by its own high input
// - filtered level equals duty times supply
// - reference clock absent while phy held reset
// - program button clears logic and done
// - system reset clears logic, keeps straps
// - system reset button pulses shield reset
// - missing power good holds logic in reset, phy reset released
`timescale 1ns/1ps
`default_nettype none
module bpio_top #(
  parameter int unsigned NUM_LED = bpio_pkg::NUM_LED,
  parameter int unsigned SHIELD_CYC = bpio_pkg::SHIELD_PULSE_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [bpio_pkg::NUM_BTN-1:0] btn_i,
  input wire logic [bpio_pkg::NUM_SW-1:0] sw_i,
  input wire logic power_good_i,
  input wire logic pl_program_n_i,
  input wire logic system_reset_button_i,
  input wire logic phy_clk_ok_i,
  input wire logic phy_reset_req_i,
  input wire logic [NUM_LED-1:0] led_set_i,
  input wire logic [bpio_pkg::PERIOD_BITS-1:0] rgb_duty_i [bpio_pkg::NUM_CHAN],
  input wire logic [bpio_pkg::PERIOD_BITS-1:0] audio_duty_i,
  input wire logic audio_enable_i,
  output logic [bpio_pkg::NUM_BTN-1:0] btn_o,
  output logic [bpio_pkg::NUM_SW-1:0] sw_o,
  output logic [NUM_LED-1:0] led_o,
  output logic [bpio_pkg::NUM_CHAN-1:0] rgb_o,
  output logic audio_pulse_out_o,
  output logic audio_pulse_out_oe_o,
  output logic audio_mute_n_o,
  output logic phy_reset_n_o,
  output logic ref_clock_valid_o,
  output logic config_done_o,
  output logic shield_reset_o
);
  localparam int unsigned PB = bpio_pkg::PERIOD_BITS;
  localparam int unsigned NC = bpio_pkg::NUM_CHAN;
  localparam int unsigned NP = bpio_pkg::NUM_BTN + bpio_pkg::NUM_SW + 3;

  // elaboration stops on a zero led count, a zero shield count or one the fixed 16-bit shield timer cannot hold
  if (NUM_LED < 1 || SHIELD_CYC < 1 || SHIELD_CYC > 65535) begin : g_bad_param
    $error("bpio_top: unsupported parameter value");
  end
  if (bpio_pkg::PWM_HZ < bpio_pkg::AUDIO_PWM_MIN_HZ) begin : g_slow_pwm
    $error("bpio_top: pulse rate too low for audio");
  end

  typedef struct packed {
    logic [NP-1:0] sync1;
    logic [NP-1:0] sync2;
    logic system_reset_button_prev;
    logic [15:0] shield_cnt;
    logic [PB-1:0] cnt;
    logic [NUM_LED-1:0] led;
    logic [NC-1:0] rgb;
    logic aud_low;
    logic mute_n;
    logic phy_n;
    logic clk_ok;
    logic done;
    logic shield;
    logic [bpio_pkg::NUM_BTN-1:0] btn;
    logic [bpio_pkg::NUM_SW-1:0] sw;
  } bpio_state_t;

  bpio_state_t s_q, s_d;
  bpio_pkg::bpio_pins_t pins;
  logic pl_clear;

  function automatic logic bpio_below(input logic [PB-1:0] c, input logic [PB-1:0] d);
    bpio_below = (c < d);
  endfunction

  always_comb begin
    pins = bpio_pkg::bpio_pins_t'(s_q.sync2);
    s_d = s_q;
    s_d.sync1 = {btn_i, sw_i, phy_clk_ok_i, system_reset_button_i, power_good_i};
    s_d.sync2 = s_q.sync1;
    s_d.system_reset_button_prev = pins.sys_rst_btn;
    s_d.cnt = s_q.cnt + 1'b1;
    s_d.btn = pins.btn;
    s_d.sw = pins.sw;
    s_d.led = led_set_i;
    for (int i = 0; i < NC; i++) begin
      // clamp so a steady high never reaches the led
      s_d.rgb[i] = bpio_below(s_q.cnt, rgb_duty_i[i]) &&
                   ({1'b0, s_q.cnt} < bpio_pkg::RGB_LIMIT);
    end
    // duty/period sets the filtered level
    s_d.aud_low = !bpio_below(s_q.cnt, audio_duty_i);
    s_d.mute_n = audio_enable_i;
    s_d.phy_n = !phy_reset_req_i;
    s_d.clk_ok = s_q.phy_n && pins.phy_clk_ok;
    s_d.done = 1'b1;
    if (pins.sys_rst_btn && !s_q.system_reset_button_prev) begin
      s_d.shield_cnt = 16'(SHIELD_CYC);
    end else if (s_q.shield_cnt != 16'h0000) begin
      s_d.shield_cnt = s_q.shield_cnt - 16'h0001;
    end
    s_d.shield = (s_d.shield_cnt != 16'h0000);
    if (pl_clear) begin
      // straps are not held here, so nothing resamples them
      // synchronisers and the shield timer run on, so the pulse lasts at least SHIELD_CYC cycles
      s_d.cnt = bpio_pkg::CNT_RESET;
      s_d.led = '0;
      s_d.rgb = '0;
      s_d.aud_low = 1'b0;
      s_d.mute_n = 1'b0;
      s_d.phy_n = 1'b1;
      s_d.clk_ok = 1'b0;
      s_d.done = 1'b0;
      s_d.btn = '0;
      s_d.sw = '0;
      s_d.shield = s_d.shield || pins.sys_rst_btn;
    end
  end

  // program button, system reset button and missing power good all clear the logic
  assign pl_clear = !pl_program_n_i || pins.sys_rst_btn || !pins.power_good;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.phy_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign btn_o = s_q.btn;
  assign sw_o = s_q.sw;
  assign led_o = s_q.led;
  assign rgb_o = s_q.rgb;
  assign audio_pulse_out_o = 1'b0;
  assign audio_pulse_out_oe_o = s_q.aud_low;
  assign audio_mute_n_o = s_q.mute_n;
  assign phy_reset_n_o = s_q.phy_n;
  assign ref_clock_valid_o = s_q.clk_ok;
  assign config_done_o = s_q.done;
  assign shield_reset_o = s_q.shield;

  // every output but the tied-low audio_pulse_out_o is registered, so each check looks one edge after its cause
  a_rgb_half_duty: assert property (@(posedge mclk_i) disable iff (rst_i)
    ($past(s_q.cnt) >= bpio_pkg::RGB_DUTY_MAX) |-> rgb_o == '0)
    else $error("rgb lit past half period");
  a_clk_absent: assert property (@(posedge mclk_i) disable iff (rst_i)
    !phy_reset_n_o |=> !ref_clock_valid_o)
    else $error("ref clock valid while phy in reset");
  a_prog_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
    !pl_program_n_i |=> !config_done_o && rgb_o == '0 && led_o == '0)
    else $error("program did not clear logic");
  a_shield_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(s_q.sync2[1]) |=> shield_reset_o)
    else $error("shield reset not raised");
  a_power_good_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    !s_q.sync2[0] |=> !config_done_o && !audio_mute_n_o)
    else $error("logic active without power good");
  a_btn_lat: assert property (@(posedge mclk_i) disable iff (rst_i)
    !pl_clear && !$past(pl_clear) |=> btn_o == $past(s_q.sync2[bpio_pkg::NUM_SW+3 +: 4]))
    else $error("button path wrong");
  a_sw_lat: assert property (@(posedge mclk_i) disable iff (rst_i)
    !pl_clear |=> sw_o == $past(s_q.sync2[4:3]))
    else $error("switch path wrong");
  a_led_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
    !pl_clear |=> led_o == $past(led_set_i))
    else $error("led does not follow");
  a_audio_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    !pl_clear && audio_duty_i == 8'h00 |=> audio_pulse_out_oe_o)
    else $error("zero duty released line");
  a_audio_release: assert property (@(posedge mclk_i) disable iff (rst_i)
    !pl_clear && s_q.cnt < audio_duty_i |=> !audio_pulse_out_oe_o)
    else $error("audio line pulled low inside pulse");
  a_audio_level: assert property (@(posedge mclk_i) disable iff (rst_i)
    !pl_clear && s_q.cnt >= audio_duty_i |=> audio_pulse_out_oe_o)
    else $error("audio line released past pulse");
  a_mute_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
    !pl_clear |=> audio_mute_n_o == $past(audio_enable_i))
    else $error("mute does not follow enable");
  a_cnt_step: assert property (@(posedge mclk_i) disable iff (rst_i)
    !pl_clear |=> s_q.cnt == PB'($past(s_q.cnt) + 1'b1))
    else $error("period counter skipped");
  a_rgb_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    !pl_clear && s_q.cnt >= rgb_duty_i[0] |=> !rgb_o[0])
    else $error("colour lit past its duty");
  a_clear_outputs: assert property (@(posedge mclk_i) disable iff (rst_i)
    pl_clear |=> rgb_o == '0 && !audio_pulse_out_oe_o && !config_done_o && !audio_mute_n_o)
    else $error("clear left outputs active");
  a_pins_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
    pl_clear |=> btn_o == '0 && sw_o == '0)
    else $error("clear left inputs visible");
  a_shield_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_q.sync2[1] |=> shield_reset_o)
    else $error("shield reset dropped while held");
  a_shield_load: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(s_q.sync2[1]) |=> s_q.shield_cnt == 16'(SHIELD_CYC))
    else $error("shield timer not loaded");
  a_phy_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> phy_reset_n_o == ($past(pl_clear) || !$past(phy_reset_req_i)))
    else $error("phy reset does not follow request");
  a_ref_clock_ok: assert property (@(posedge mclk_i) disable iff (rst_i)
    !pl_clear && phy_reset_n_o && s_q.sync2[2] |=> ref_clock_valid_o)
    else $error("ref clock not reported valid");
endmodule // bpio_top
`default_nettype wire

// >>> verif/bpio_board_model.sv
// board model: pull-up on the audio line and a duty counter standing for the filter
// assumes the bench clears the counter, then samples it after whole pulse periods
`timescale 1ns/1ps
`default_nettype none
module bpio_board_model (
  input wire logic mclk_i,
  input wire logic clr_i,
  input wire logic oe_i,
  input wire logic drv_i,
  output logic line_o,
  output var int high_cnt_o
);
  // no real filter: a count of high cycles gives the settled level exactly
  assign line_o = oe_i ? drv_i : 1'b1;
  always_ff @(posedge mclk_i) begin
    high_cnt_o <= clr_i ? 0 : high_cnt_o + int'(line_o);
  end
endmodule // bpio_board_model
`default_nettype wire

// >>> verif/tb.sv
// testbench for bpio_top: pins driven at the falling edge, outputs judged there
// assumes SHIELD_CYC shortened to 4
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk_i = 0, rst_i = 1, power_good_i = 1, pl_program_n_i = 1, sys_btn = 0;
  logic phy_clk_ok_i = 1, phy_req = 0, audio_enable_i = 0, clr = 0;
  logic [3:0] btn_i = '0, led_set_i = '0, btn_o, led_o;
  logic [1:0] sw_i = '0, sw_o;
  logic [7:0] rgb_duty_i [6] = '{default: 8'h00};
  logic [7:0] audio_duty_i = 8'h00;
  logic [5:0] rgb_o;
  logic aud, aud_oe, mute_n, phy_n, ref_ok, done, shield, line;
  int error_cnt = 0, n_checks = 0, hc;
  localparam int unsigned SHIELD_TB = 4;
  bpio_top #(.SHIELD_CYC(SHIELD_TB)) bpio_top_inst (.mclk_i(mclk_i), .rst_i(rst_i), .btn_i(btn_i),
    .sw_i(sw_i), .power_good_i(power_good_i), .pl_program_n_i(pl_program_n_i),
    .system_reset_button_i(sys_btn), .phy_clk_ok_i(phy_clk_ok_i), .phy_reset_req_i(phy_req),
    .led_set_i(led_set_i), .rgb_duty_i(rgb_duty_i), .audio_duty_i(audio_duty_i),
    .audio_enable_i(audio_enable_i), .btn_o(btn_o), .sw_o(sw_o), .led_o(led_o), .rgb_o(rgb_o),
    .audio_pulse_out_o(aud), .audio_pulse_out_oe_o(aud_oe), .audio_mute_n_o(mute_n),
    .phy_reset_n_o(phy_n), .ref_clock_valid_o(ref_ok), .config_done_o(done),
    .shield_reset_o(shield));
  bpio_board_model bpio_board_model_inst (.mclk_i(mclk_i), .clr_i(clr), .oe_i(aud_oe),
    .drv_i(aud), .line_o(line), .high_cnt_o(hc));
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_pins;
    btn_i = 4'hA;
    sw_i = 2'h1;
    led_set_i = 4'h5;
    cyc(4);
    chk(btn_o, 4'hA);
    chk(sw_o, 2'h1);
    chk(led_o, 4'h5);
    chk(done, 1'b1);
    chk(ref_ok, 1'b1);
    btn_i = 4'h0;
    cyc(4);
    chk(btn_o, 4'h0);
    $display("pins done");
  endtask
  task automatic t_pwm;
    int c [6];
    int rises = 0;
    logic line_prev;
    c = '{default: 0};
    rgb_duty_i = '{8'hC8, 8'h40, 8'h80, 8'h00, 8'hFF, 8'h01};
    audio_duty_i = 8'h40;
    audio_enable_i = 1;
    cyc(3);
    clr = 1;
    cyc(1);
    clr = 0;
    line_prev = line;
    for (int k = 0; k < 256; k++) begin
      cyc(1);
      for (int j = 0; j < 6; j++) c[j] += rgb_o[j];
      if (line && !line_prev) rises++;
      line_prev = line;
    end
    chk(c[0], 128);
    chk(c[1], 64);
    chk(c[2], 128);
    chk(c[3], 0);
    chk(c[4], bpio_pkg::RGB_DUTY_MAX);
    chk(c[5], 1);
    // one audio pulse per 256 cycles keeps the rate above ten times 5 kHz
    chk(rises, 1);
    chk(hc, 64);
    chk({aud, mute_n}, 2'h1);
    audio_enable_i = 0;
    cyc(2);
    chk(mute_n, 0);
    $display("pwm done");
  endtask
  task automatic t_resets;
    int n = 0;
    phy_req = 1;
    cyc(4);
    chk({phy_n, ref_ok}, 2'h0);
    phy_req = 0;
    pl_program_n_i = 0;
    cyc(2);
    chk({done, led_o}, 5'h00);
    pl_program_n_i = 1;
    power_good_i = 0;
    cyc(4);
    chk({done, led_o, rgb_o}, 11'h000);
    power_good_i = 1;
    sys_btn = 1;
    cyc(2);
    sys_btn = 0;
    for (int k = 0; k < 20; k++) begin
      cyc(1);
      if (shield === 1'b1) n++;
      if (k == 0) chk({done, led_o}, 5'h00);
    end
    chk(n, SHIELD_TB);
    chk(shield, 0);
    $display("resets done");
  endtask
  task automatic t_midrun_reset;
    led_set_i = 4'hF;
    rst_i = 1;
    cyc(2);
    chk({led_o, rgb_o, done, phy_n, shield}, 13'h0002);
    rst_i = 0;
    cyc(4);
    chk({done, led_o}, 5'h1F);
    $display("midrun reset done");
  endtask
  initial begin
    #4_000_000;
    error_cnt++;
    print_verdict;
  end
  initial begin
    cyc(8);
    chk({led_o, rgb_o, done, phy_n}, 12'h001);
    rst_i = 0;
    t_pins;
    t_pwm;
    t_resets;
    t_midrun_reset;
    print_verdict;
  end
endmodule // tb
`default_nettype wire
